//--- logic/pad_ctrl_pkg.sv
// Constants for the core port pad and E clock control block
package pad_ctrl_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_PULL = 6'h0C;
  localparam logic [5:0] IDX_DRIVE = 6'h0D;
  localparam logic [5:0] IDX_EBI = 6'h0E;
  localparam logic [5:0] IDX_RSVD = 6'h0F;

  // Field positions shared by the pull and drive registers, then the stretch enable bit
  localparam int BIT_K = 7;
  localparam int BIT_E = 4;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;
  localparam int BIT_ECLK_STRETCH_EN = 0;

  // Implemented bits; all others read zero
  localparam logic [7:0] PORT_MASK = 8'h93;
  localparam logic [7:0] EBI_MASK = 8'h01;

  // Port E pins whose pull follows the enable bit
  localparam logic [7:0] PE_SW_PULL = 8'h9F;
  // Port E pins pulled only while reset is held
  localparam logic [7:0] PE_RST_PULL = 8'h60;

  // Reset values
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic ECLK_STRETCH_EN_RST = 1'b0;

  // Operating mode codes {C,B,A}
  localparam logic [2:0] MODE_SPEC_SINGLE = 3'h0;
  localparam logic [2:0] MODE_EMU_NARROW = 3'h1;
  localparam logic [2:0] MODE_SPEC_TEST = 3'h2;
  localparam logic [2:0] MODE_EMU_WIDE = 3'h3;
  localparam logic [2:0] MODE_NORM_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NORM_NARROW = 3'h5;
  localparam logic [2:0] MODE_SPEC_PERIPH = 3'h6;
  localparam logic [2:0] MODE_NORM_WIDE = 3'h7;

endpackage

//--- logic/core_port_pad_and_eclk_control.sv
// Pull, drive strength and E clock control registers on classic Wishbone
`timescale 1ns/1ps

// Contract
// - Port K enable pulls input pins
// - Port E enable covers pins 7, 4:0
// - Port E pins 5,6 pulled only in reset
// - Port B enable pulls input pins
// - Port A enable pulls input pins
// - Output pins get no pull outside reset
// - Weak drive selects for ports K, E
// - Weak drive selects for ports B, A
// - Weak drive applies whatever function owns pin
// - Registers read/write anytime while mapped
// - Expanded/peripheral modes: accesses go external
// - Stretch off: E clock free running
// - Stretch on: high stretched, low internal
// - Stretch bit write once unless special
// - Single-chip: stretch bit has no effect
// - Reserved location reads zero, ignores writes
// - Offsets relative to relocatable block base
// - Pull register sits at index 0x0C
module core_port_pad_and_eclk_control #(
  parameter int AW = 16 // Byte address width
) (
  input wire logic clk, // 125 MHz bus clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [AW-1:0] wbAdr, // Byte address
  input wire logic [31:0] wbDatI, // Write data
  output logic [31:0] wbDatO, // Read data
  input wire logic [3:0] wbSel, // Byte lanes
  input wire logic wbWe, // Write strobe
  input wire logic wbCyc, // Bus cycle
  input wire logic wbStb, // Strobe
  output logic wbAck, // Acknowledge
  input wire logic [AW-9:0] registerBlockRelocation, // Block base bits
  input wire logic [2:0] opMode, // Operating mode {C,B,A}
  input wire logic [7:0] ddrK, // Port K directions, 1 = out
  input wire logic [7:0] ddrE, // Port E directions, 1 = out
  input wire logic [7:0] ddrB, // Port B directions, 1 = out
  input wire logic [7:0] ddrA, // Port A directions, 1 = out
  input wire logic eclkPhase, // Free running E phase
  input wire logic extStretch, // Stretched external access
  input wire logic intHidden, // Non-visible internal access
  output logic [7:0] pullK, // Port K pull enables
  output logic [7:0] pullE, // Port E pull enables
  output logic [7:0] pullB, // Port B pull enables
  output logic [7:0] pullA, // Port A pull enables
  output logic weakDriveK, // Port K reduced drive
  output logic weakDriveE, // Port E reduced drive
  output logic weakDriveB, // Port B reduced drive
  output logic weakDriveA, // Port A reduced drive
  output logic eclkOut, // E clock to pin
  output logic extEcho, // Access passed to external bus
  output logic extEchoWe // Direction of that access
);

  typedef struct packed {
    logic [7:0] pullCtl;
    logic [7:0] driveCtl;
    logic eclkStretchEn;
    logic estrLocked;
    logic ack;
    logic [31:0] rdData;
    logic echo;
    logic echoWe;
    logic [7:0] pullK;
    logic [7:0] pullE;
    logic [7:0] pullB;
    logic [7:0] pullA;
    logic weakK;
    logic weakE;
    logic weakB;
    logic weakA;
    logic eclk;
  } state_t;

  // Reset image; port E pins 5 and 6 pulled only while reset holds
  localparam state_t RESET_STATE = '{
    pullCtl: pad_ctrl_pkg::PULL_RST,
    driveCtl: pad_ctrl_pkg::DRIVE_RST,
    eclkStretchEn: pad_ctrl_pkg::ECLK_STRETCH_EN_RST,
    estrLocked: 1'b0,
    ack: 1'b0,
    rdData: 32'h00000000,
    echo: 1'b0,
    echoWe: 1'b0,
    pullK: 8'h00,
    pullE: pad_ctrl_pkg::PE_RST_PULL,
    pullB: 8'h00,
    pullA: 8'h00,
    weakK: 1'b0,
    weakE: 1'b0,
    weakB: 1'b0,
    weakA: 1'b0,
    eclk: 1'b0
  };

  state_t st;
  state_t next_st;

  // Registers are mapped only in single-chip and special test modes
  function automatic logic inMap(input logic [2:0] m);
    return (m == pad_ctrl_pkg::MODE_SPEC_SINGLE) ||
      (m == pad_ctrl_pkg::MODE_SPEC_TEST) ||
      (m == pad_ctrl_pkg::MODE_NORM_SINGLE);
  endfunction

  function automatic logic isSpecial(input logic [2:0] m);
    return (m == pad_ctrl_pkg::MODE_SPEC_SINGLE) ||
      (m == pad_ctrl_pkg::MODE_SPEC_TEST) ||
      (m == pad_ctrl_pkg::MODE_SPEC_PERIPH);
  endfunction

  function automatic logic isSingleChip(input logic [2:0] m);
    return (m == pad_ctrl_pkg::MODE_SPEC_SINGLE) ||
      (m == pad_ctrl_pkg::MODE_NORM_SINGLE);
  endfunction

  // Pull only where the pin is an input
  function automatic logic [7:0] pullFor(input logic en,
                                         input logic [7:0] ddr);
    return {8{en}} & ~ddr;
  endfunction

  // Next state: bus slave, control registers and pad outputs
  always_comb begin
    logic req;
    logic hit;
    logic [5:0] idx;
    logic [2:0] stretchPick;
    req = 1'b0;
    hit = 1'b0;
    idx = 6'h00;
    stretchPick = 3'h0;
    next_st = st;
    next_st.ack = 1'b0;
    next_st.echo = 1'b0;
    next_st.echoWe = 1'b0;
    req = wbCyc & wbStb & ~st.ack;
    hit = (wbAdr[AW-1:8] == registerBlockRelocation);
    idx = wbAdr[7:2];
    if (req) begin
      // Every request answers in one cycle, mapped or not
      next_st.ack = 1'b1;
      next_st.rdData = 32'h00000000;
      if (hit && !inMap(opMode)) begin
        // Left to the external bus; reads return zero here
        next_st.echo = 1'b1;
        next_st.echoWe = wbWe;
      end else if (hit) begin
        case (idx)
          pad_ctrl_pkg::IDX_PULL: begin
            next_st.rdData[7:0] = st.pullCtl;
            if (wbWe && wbSel[0]) begin
              next_st.pullCtl = wbDatI[7:0] &
                pad_ctrl_pkg::PORT_MASK;
            end
          end
          pad_ctrl_pkg::IDX_DRIVE: begin
            next_st.rdData[7:0] = st.driveCtl;
            if (wbWe && wbSel[0]) begin
              next_st.driveCtl = wbDatI[7:0] &
                pad_ctrl_pkg::PORT_MASK;
            end
          end
          pad_ctrl_pkg::IDX_EBI: begin
            next_st.rdData[7:0] = {7'h00, st.eclkStretchEn};
            if (wbWe && wbSel[0]) begin
              // Normal and emulation modes get one write only
              if (isSpecial(opMode) || !st.estrLocked) begin
                next_st.eclkStretchEn =
                  wbDatI[pad_ctrl_pkg::BIT_ECLK_STRETCH_EN];
              end
              if (!isSpecial(opMode)) begin
                next_st.estrLocked = 1'b1;
              end
            end
          end
          // Reserved slot and anything else: zero, writes dropped
          default: begin
            next_st.rdData = 32'h00000000;
          end
        endcase
      end
    end
    // Pull enables, masked per pin by direction
    next_st.pullK = pullFor(st.pullCtl[pad_ctrl_pkg::BIT_K],
                            ddrK);
    next_st.pullE = pullFor(st.pullCtl[pad_ctrl_pkg::BIT_E], ddrE) &
      pad_ctrl_pkg::PE_SW_PULL;
    next_st.pullB = pullFor(st.pullCtl[pad_ctrl_pkg::BIT_B],
                            ddrB);
    next_st.pullA = pullFor(st.pullCtl[pad_ctrl_pkg::BIT_A],
                            ddrA);
    // Drive strength is per port, not per pin or function
    next_st.weakK = st.driveCtl[pad_ctrl_pkg::BIT_K];
    next_st.weakE = st.driveCtl[pad_ctrl_pkg::BIT_E];
    next_st.weakB = st.driveCtl[pad_ctrl_pkg::BIT_B];
    next_st.weakA = st.driveCtl[pad_ctrl_pkg::BIT_A];
    // E clock: stretching only outside single-chip modes with the bit set
    stretchPick = {st.eclkStretchEn & ~isSingleChip(opMode),
                   extStretch, intHidden};
    if (!stretchPick[2]) begin
      next_st.eclk = eclkPhase;
    end else if (stretchPick[1]) begin
      next_st.eclk = 1'b1;
    end else if (stretchPick[0]) begin
      next_st.eclk = 1'b0;
    end else begin
      next_st.eclk = eclkPhase;
    end
  end

  // One register for the whole state; reset loads constants only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wbAck = st.ack;
  assign wbDatO = st.rdData;
  assign pullK = st.pullK;
  assign pullE = st.pullE;
  assign pullB = st.pullB;
  assign pullA = st.pullA;
  assign weakDriveK = st.weakK;
  assign weakDriveE = st.weakE;
  assign weakDriveB = st.weakB;
  assign weakDriveA = st.weakA;
  assign eclkOut = st.eclk;
  assign extEcho = st.echo;
  assign extEchoWe = st.echoWe;

endmodule

//--- sim/pad_ctrl_props.sv
// Port-level assertions for the pad control block
`timescale 1ns/1ps
module pad_ctrl_props (
  input logic clk, // Bus clock
  input logic sys_rst, // Reset
  input logic wbCyc, // Cycle
  input logic wbStb, // Strobe
  input logic wbAck, // Ack
  input logic [31:0] wbDatO, // Read data
  input logic [7:0] ddrK, // K dirs
  input logic [7:0] pullK, // K pulls
  input logic [7:0] pullE, // E pulls
  input logic eclkPhase, // E phase
  input logic extStretch, // Stretch
  input logic intHidden, // Hidden
  input logic eclkOut, // E clock
  input logic extEcho // Echo
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Request taken, then exactly one ack cycle
  sequence takenS; wbCyc && wbStb && !wbAck; endsequence
  sequence ackS; wbAck ##1 !wbAck; endsequence
  a_ack_one: assert property (takenS |=> ackS)
    else $error("ack not a single pulse");
  a_ack_cause: assert property (wbAck |-> $past(wbStb))
    else $error("ack without request");
  a_data_upper: assert property (wbAck |-> wbDatO[31:8] == 24'h0)
    else $error("upper read data set");
  a_pull_out: assert property (!$past(sys_rst) |->
    (pullK & $past(ddrK)) == 8'h00) else $error("pull on output");
  a_pe_rst: assert property (!$past(sys_rst) |-> pullE[6:5] == 2'h0)
    else $error("port E 5,6 pulled");
  a_eclk_free: assert property (!$past(sys_rst) && !$past(extStretch)
    && !$past(intHidden) |-> eclkOut == $past(eclkPhase))
    else $error("E clock not free");
  a_echo_ack: assert property (extEcho |-> wbAck && wbDatO == 32'h0)
    else $error("echo without ack");
  a_echo_once: assert property (extEcho |=> !extEcho)
    else $error("echo too long");
endmodule
bind core_port_pad_and_eclk_control pad_ctrl_props pad_ctrl_props_i (
  .clk, .sys_rst, .wbCyc, .wbStb, .wbAck, .wbDatO, .ddrK, .pullK, .pullE,
  .eclkPhase, .extStretch, .intHidden, .eclkOut, .extEcho);

//--- sim/ext_bus_model.sv
// Far side of the expanded bus: E phase and access kinds
`timescale 1ns/1ps
module ext_bus_model (
  input logic clk, // Bus clock
  input logic sys_rst, // Reset
  input logic [1:0] kind, // 0 idle, 1 stretched, 2 hidden
  input logic extEcho, // Echoed access
  output logic eclkPhase = 1'h0, // Free E phase
  output logic extStretch = 1'h0, // Stretched access
  output logic intHidden = 1'h0, // Hidden access
  output int nEcho = 0 // Echoes seen
);
  // Phase runs on through reset, like a divider off the bus clock
  always @(posedge clk) begin
    eclkPhase <= !eclkPhase;
    extStretch <= (kind == 2'h1);
    intHidden <= (kind == 2'h2);
    nEcho <= sys_rst ? 0 : nEcho + int'(extEcho);
  end
endmodule

//--- sim/core_port_pad_and_eclk_control_tb.sv
// Self-checking bench for the pad control block
`timescale 1ns/1ps
module core_port_pad_and_eclk_control_tb;
  logic clk = 1'h0, sys_rst = 1'h1, wbWe = 1'h0, wbCyc = 1'h0, wbStb = 1'h0;
  logic [15:0] wbAdr = 16'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO;
  logic [7:0] ddr = 8'h00, pullK, pullE, pullB, pullA, q;
  logic [2:0] opMode = 3'h2;
  logic [1:0] kind = 2'h0;
  logic wbAck, wdK, wdE, wdB, wdA, eclkOut, extEcho, eclkPhase;
  logic extStretch, intHidden, e, echoWe, ew;
  int n_fail = 0, n_tests = 0, nEcho;
  core_port_pad_and_eclk_control core_port_pad_and_eclk_control_i (.clk,
    .sys_rst, .wbAdr, .wbDatI, .wbDatO, .wbSel(4'h1), .wbWe, .wbCyc, .wbStb,
    .wbAck, .registerBlockRelocation(8'h12), .opMode, .ddrK(ddr),
    .ddrE(ddr), .ddrB(ddr), .ddrA(ddr), .eclkPhase, .extStretch, .intHidden,
    .pullK, .pullE, .pullB, .pullA, .weakDriveK(wdK), .weakDriveE(wdE),
    .weakDriveB(wdB), .weakDriveA(wdA), .eclkOut, .extEcho,
    .extEchoWe(echoWe));
  ext_bus_model ext_bus_model_i (.clk, .sys_rst, .kind, .extEcho,
    .eclkPhase, .extStretch, .intHidden, .nEcho);
  always #4 clk = ~clk;
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One classic cycle; holds everything until ack is sampled
  task bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wbAdr, wbWe, wbDatI, wbCyc, wbStb} <= {a, w, 24'h0, d, 2'h3};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'h1 && n < 20);
    // A missing ack ends the run at the verdict
    if (n >= 20) begin
      n_fail++;
      final_report;
    end
    q = wbDatO[7:0];
    e = extEcho;
    ew = echoWe;
    {wbCyc, wbStb} <= 2'h0;
  endtask
  task settle(input logic [1:0] k);
    kind <= k;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task do_reset(input logic [2:0] m);
    @(posedge clk);
    {sys_rst, opMode} <= {1'h1, m};
    repeat (3) @(posedge clk);
    chk("pullE reset", pullE, 8'h60);
    sys_rst <= 1'h0;
  endtask
  task t_regs;
    bus(16'h1230, 1'h1, 8'hFF);
    bus(16'h1230, 1'h0, 8'h00);
    chk("pull", q, 8'h93);
    bus(16'h1234, 1'h1, 8'hFF);
    bus(16'h1234, 1'h0, 8'h00);
    chk("drive", q, 8'h93);
    bus(16'h123C, 1'h1, 8'hFF);
    bus(16'h123C, 1'h0, 8'h00);
    chk("reserved", q, 8'h00);
    bus(16'h0030, 1'h0, 8'h00);
    chk("wrong base", q, 8'h00);
    bus(16'h1238, 1'h1, 8'hFF);
    $display("t_regs done");
  endtask
  task t_pads;
    settle(2'h0);
    chk("pullK", pullK, 8'hFF);
    chk("pullE", pullE, 8'h9F);
    chk("pullB", pullB, 8'hFF);
    chk("pullA", pullA, 8'hFF);
    ddr <= 8'h0F;
    settle(2'h0);
    chk("pullK out", pullK, 8'hF0);
    chk("pullE out", pullE, 8'h90);
    chk("weak", {4'h0, wdK, wdE, wdB, wdA}, 8'h0F);
    $display("t_pads done");
  endtask
  // Stretch bit: free writes in special mode, one write in normal mode
  task t_eclk_stretch_en;
    settle(2'h1);
    chk("eclk stretched", {7'h0, eclkOut}, 8'h01);
    settle(2'h2);
    chk("eclk hidden", {7'h0, eclkOut}, 8'h00);
    bus(16'h1238, 1'h1, 8'h00);
    bus(16'h1238, 1'h0, 8'h00);
    chk("eclk_stretch_en special", q, 8'h00);
    do_reset(3'h4);
    bus(16'h1238, 1'h1, 8'h01);
    bus(16'h1238, 1'h1, 8'h00);
    bus(16'h1238, 1'h0, 8'h00);
    chk("eclk_stretch_en once", q, 8'h01);
    settle(2'h1);
    chk("eclk single", {7'h0, eclkOut}, {7'h0, !eclkPhase});
    $display("t_eclk_stretch_en done");
  endtask
  task t_echo;
    do_reset(3'h5);
    bus(16'h1230, 1'h1, 8'hFF);
    chk("echo wr", {7'h0, e}, 8'h01);
    chk("echo dir wr", {7'h0, ew}, 8'h01);
    bus(16'h1230, 1'h0, 8'h00);
    chk("echo rd", {7'h0, e}, 8'h01);
    chk("echo dir rd", {7'h0, ew}, 8'h00);
    chk("echo data", q, 8'h00);
    opMode <= 3'h2;
    bus(16'h1230, 1'h0, 8'h00);
    chk("pull kept", q, 8'h00);
    chk("echo count", 8'(nEcho), 8'h02);
    $display("t_echo done");
  endtask
  task final_report;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    do_reset(3'h2);
    t_regs;
    t_pads;
    t_eclk_stretch_en;
    t_echo;
    final_report;
  end
  // Run needs under a hundred cycles; this is far beyond
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
endmodule
